/* File: seidpl_map.vh */
// Constants of the identification-page access block
`ifndef SEIDPL_MAP_VH
`define SEIDPL_MAP_VH

`define SEIDPL_ID_BYTES 32
`define SEIDPL_OFS_W 5
`define SEIDPL_ADR_W 16
`define SEIDPL_REGION_BIT 10
`define SEIDPL_LOCK_DATA_BIT 1
`define SEIDPL_LOCK_STAT_BIT 0
`define SEIDPL_ERASED_BYTE 8'hff
`define SEIDPL_CLK_PERIOD_NS 4
`define SEIDPL_WRITE_TIME_NS 1000000
`define SEIDPL_FIFO_DEPTH 32
`define SEIDPL_OP_RD_ID 8'h31
`define SEIDPL_OP_RD_LOCK 8'h31
`define SEIDPL_OP_WR_ID 8'h32
`define SEIDPL_OP_LOCK_ID 8'h32
`define SEIDPL_OP_WRITE_LATCH_SET_CMD 8'h35
`define SEIDPL_OP_WRDI 8'h36

`endif

/* File: seidpl_fifo.v */
// Synchronous FIFO with flush, valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module seidpl_fifo #(
	parameter WIDTH = 13,
	parameter DEPTH = 32,
	parameter AW = 5
) (
	input wire clk_i,
	input wire sys_rst_i,
	input wire flush_i,
	input wire in_valid_i,
	input wire [WIDTH-1:0] in_data_i,
	output wire in_ready_o,
	output wire out_valid_o,
	output wire [WIDTH-1:0] out_data_o,
	input wire out_ready_i
);
	reg [WIDTH-1:0] mem_r [0:DEPTH-1];
	reg [AW:0] wr_ptr_r;
	reg [AW:0] rd_ptr_r;
	wire empty = (wr_ptr_r == rd_ptr_r);
	wire full = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
	wire push = in_valid_i & ~full;
	wire pop = out_ready_i & ~empty;

	assign in_ready_o = ~full;
	assign out_valid_o = ~empty;
	assign out_data_o = mem_r[rd_ptr_r[AW-1:0]];

	always @(posedge clk_i) begin
		if (push) begin
			mem_r[wr_ptr_r[AW-1:0]] <= in_data_i;
		end
	end

	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wr_ptr_r <= {(AW+1){1'b0}};
			rd_ptr_r <= {(AW+1){1'b0}};
		end else if (flush_i) begin
			wr_ptr_r <= {(AW+1){1'b0}};
			rd_ptr_r <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
		end
	end
endmodule

`default_nettype wire

/* File: seidpl_core.v */
// Identification page, lock flag and their serial instructions
//
// How it works
// (RQ1) Separate 32-byte page, writable then lockable
// (RQ2) ID read: region bit 0, offset picks byte
// (RQ3) Address increments after each byte read
// (RQ4) Master stays within 32 bytes per read
// (RQ5) Select rise ends read at any time
// (RQ6) ID read ignored while write busy
// (RQ7) ID write: region bit 0, offset positions
// (RQ8) Lock status read uses region bit 1
// (RQ9) Lock flag is status byte bit zero
// (RQ10) Status byte repeats while select low
// (RQ11) Lock needs write enable latch set first
// (RQ12) Lock data byte needs bit one set
// (RQ13) Select must rise right after eighth bit
// (RQ14) Valid lock starts self-timed write cycle
// (RQ15) Lock discarded when busy, protected, misaligned
// (RQ16) Completed lock is permanent, read-only page
// (RQ17) Power-up deselected; needs select falling edge
// (RQ18) Power-up clears latch and busy flag
// (RQ19) Protect bits come from non-volatile store
// (RQ20) Delivered page reads all ones, unlocked
// (RQ21) Busy flag clears when write ends
// (RQ22) Write enable instruction sets the latch
// (RQ23) Opcodes are module parameters
// (RQ24) Locked page refuses ID writes
`timescale 1ns/1ps
`default_nettype none
`include "seidpl_map.vh"

module seidpl_core #(
	// (RQ23) opcodes as parameters
	parameter [7:0] OP_RD_ID = `SEIDPL_OP_RD_ID,
	parameter [7:0] OP_RD_LOCK = `SEIDPL_OP_RD_LOCK,
	parameter [7:0] OP_WR_ID = `SEIDPL_OP_WR_ID,
	parameter [7:0] OP_LOCK_ID = `SEIDPL_OP_LOCK_ID,
	parameter [7:0] OP_WRITE_LATCH_SET_CMD = `SEIDPL_OP_WRITE_LATCH_SET_CMD,
	parameter [7:0] OP_WRDI = `SEIDPL_OP_WRDI,
	parameter WRITE_TIME_NS = `SEIDPL_WRITE_TIME_NS,
	parameter FIFO_DEPTH = `SEIDPL_FIFO_DEPTH
) (
	input wire clk_i,
	input wire sys_rst_i,
	input wire sel_n_i,
	input wire sck_i,
	input wire mosi_i,
	input wire protect_level_hi_i,
	input wire protect_level_lo_i,
	output reg miso_o,
	output reg miso_oe_o,
	output reg write_enable_latch_o,
	output reg write_busy_flag_o,
	output reg id_locked_o
);
	localparam OFS_W = `SEIDPL_OFS_W;
	localparam PAGE_N = `SEIDPL_ID_BYTES;
	localparam [31:0] WRITE_CYCLES_RAW = WRITE_TIME_NS / `SEIDPL_CLK_PERIOD_NS;
	localparam [31:0] WRITE_CYCLES = (WRITE_CYCLES_RAW < 32'h1) ? 32'h1 : WRITE_CYCLES_RAW;
	localparam FW = OFS_W + 8;

	localparam [2:0] SM_IDLE = 3'h0;
	localparam [2:0] SM_OPC = 3'h1;
	localparam [2:0] SM_ADR = 3'h2;
	localparam [2:0] SM_WDAT = 3'h3;
	localparam [2:0] SM_RDAT = 3'h4;
	localparam [2:0] SM_SKIP = 3'h5;

	function is_read_op;
		input [7:0] op;
		begin
			is_read_op = (op == OP_RD_ID) || (op == OP_RD_LOCK);
		end
	endfunction

	function is_write_op;
		input [7:0] op;
		begin
			is_write_op = (op == OP_WR_ID) || (op == OP_LOCK_ID);
		end
	endfunction

	// Pin synchronisers
	reg sel_s1_r;
	reg sel_s2_r;
	reg sel_s3_r;
	reg sck_s1_r;
	reg sck_s2_r;
	reg sck_s3_r;
	reg mosi_s1_r;
	reg mosi_s2_r;

	reg [2:0] state_r;
	reg [2:0] bit_cnt_r;
	reg [7:0] sh_in_r;
	reg [7:0] opc_r;
	reg [7:0] adr_hi_r;
	reg adr_cnt_r;
	reg [OFS_W-1:0] ofs_r;
	reg lock_rd_r;
	reg wr_ok_r;
	reg lk_ok_r;
	reg [1:0] nbytes_r;
	reg lock_bit_r;
	reg [7:0] out_sh_r;
	reg [31:0] wcnt_r;
	reg lock_job_r;
	reg flush_r;
	reg push_r;
	reg [FW-1:0] push_data_r;
	reg [7:0] page_r [0:PAGE_N-1];

	wire sck_rise = sck_s2_r & ~sck_s3_r;
	wire sck_fall = ~sck_s2_r & sck_s3_r;
	wire sel_rise = sel_s2_r & ~sel_s3_r;
	// (RQ17) a frame only starts on a seen falling edge
	wire sel_fall = ~sel_s2_r & sel_s3_r;
	wire [7:0] sh_nxt = {sh_in_r[6:0], mosi_s2_r};
	wire [`SEIDPL_ADR_W-1:0] adr_nxt = {adr_hi_r, sh_nxt};
	wire region_nxt = adr_nxt[`SEIDPL_REGION_BIT];
	wire [OFS_W-1:0] ofs_nxt = adr_nxt[OFS_W-1:0];
	wire [OFS_W-1:0] ofs_inc = ofs_r + 1'b1;
	// (RQ9) lock flag in the least significant bit
	wire [7:0] stat_byte = {7'h00, id_locked_o} << `SEIDPL_LOCK_STAT_BIT;
	// (RQ15) both protect bits set blocks the lock
	// (RQ19) levels kept in the non-volatile store
	wire prot_all = protect_level_hi_i & protect_level_lo_i;

	wire fifo_in_ready;
	wire fifo_out_valid;
	wire [FW-1:0] fifo_out_data;
	wire drain = write_busy_flag_o & ~lock_job_r;
	wire pop = drain & fifo_out_valid;

	seidpl_fifo #(
		.WIDTH(FW),
		.DEPTH(FIFO_DEPTH),
		.AW(OFS_W)
	) u_fifo (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.flush_i(flush_r),
		.in_valid_i(push_r),
		.in_data_i(push_data_r),
		.in_ready_o(fifo_in_ready),
		.out_valid_o(fifo_out_valid),
		.out_data_o(fifo_out_data),
		.out_ready_i(drain)
	);

	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sel_s1_r <= 1'b0;
			sel_s2_r <= 1'b0;
			sel_s3_r <= 1'b0;
			sck_s1_r <= 1'b0;
			sck_s2_r <= 1'b0;
			sck_s3_r <= 1'b0;
			mosi_s1_r <= 1'b0;
			mosi_s2_r <= 1'b0;
		end else begin
			sel_s1_r <= sel_n_i;
			sel_s2_r <= sel_s1_r;
			sel_s3_r <= sel_s2_r;
			sck_s1_r <= sck_i;
			sck_s2_r <= sck_s1_r;
			sck_s3_r <= sck_s2_r;
			mosi_s1_r <= mosi_i;
			mosi_s2_r <= mosi_s1_r;
		end
	end

	// (RQ1) page storage, one flip-flop byte per offset
	genvar g;
	generate
		for (g = 0; g < PAGE_N; g = g + 1) begin : g_page
			always @(posedge clk_i or posedge sys_rst_i) begin
				if (sys_rst_i) begin
					// (RQ20) delivered page all ones
					page_r[g] <= `SEIDPL_ERASED_BYTE;
				end else if (pop && fifo_out_data[FW-1:8] == g) begin
					// (RQ7) byte placed at its offset
					page_r[g] <= fifo_out_data[7:0];
				end
			end
		end
	endgenerate

	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			// (RQ17) standby and deselected after power-up
			state_r <= SM_IDLE;
			bit_cnt_r <= 3'h0;
			sh_in_r <= 8'h00;
			opc_r <= 8'h00;
			adr_hi_r <= 8'h00;
			adr_cnt_r <= 1'b0;
			ofs_r <= {OFS_W{1'b0}};
			lock_rd_r <= 1'b0;
			wr_ok_r <= 1'b0;
			lk_ok_r <= 1'b0;
			nbytes_r <= 2'h0;
			lock_bit_r <= 1'b0;
			out_sh_r <= 8'h00;
			miso_o <= 1'b0;
			miso_oe_o <= 1'b0;
			// (RQ18) latch and busy flag cleared at power-up
			write_enable_latch_o <= 1'b0;
			write_busy_flag_o <= 1'b0;
			// (RQ20) delivered unlocked
			id_locked_o <= 1'b0;
			wcnt_r <= 32'h0;
			lock_job_r <= 1'b0;
			flush_r <= 1'b0;
			push_r <= 1'b0;
			push_data_r <= {FW{1'b0}};
		end else begin
			flush_r <= 1'b0;
			push_r <= 1'b0;
			if (write_busy_flag_o) begin
				wcnt_r <= wcnt_r - 32'h1;
				if (wcnt_r == 32'h1) begin
					// (RQ21) busy flag clears at end of write
					write_busy_flag_o <= 1'b0;
					lock_job_r <= 1'b0;
					flush_r <= 1'b1;
					// (RQ16) lock is set here; only reset clears it
					if (lock_job_r) begin
						id_locked_o <= 1'b1;
					end
				end
			end
			if (sel_rise) begin
				// (RQ5) select rise ends any instruction
				state_r <= SM_IDLE;
				miso_oe_o <= 1'b0;
				if (state_r == SM_WDAT && bit_cnt_r == 3'h0 && !write_busy_flag_o &&
					wr_ok_r && nbytes_r != 2'h0) begin
					write_busy_flag_o <= 1'b1;
					wcnt_r <= WRITE_CYCLES;
					write_enable_latch_o <= 1'b0;
				// (RQ13) exactly one data byte, then select
				end else if (state_r == SM_WDAT && bit_cnt_r == 3'h0 &&
					!write_busy_flag_o && lk_ok_r && nbytes_r == 2'h1 &&
					lock_bit_r && !prot_all) begin
					// (RQ14) lock starts the self-timed cycle
					write_busy_flag_o <= 1'b1;
					lock_job_r <= 1'b1;
					wcnt_r <= WRITE_CYCLES;
					write_enable_latch_o <= 1'b0;
				end else if (state_r == SM_WDAT && !write_busy_flag_o) begin
					// (RQ15) discarded: staged bytes dropped, running write kept
					flush_r <= 1'b1;
				end
			end else if (sel_fall) begin
				state_r <= SM_OPC;
				bit_cnt_r <= 3'h0;
				adr_cnt_r <= 1'b0;
				nbytes_r <= 2'h0;
				lock_bit_r <= 1'b0;
				wr_ok_r <= 1'b0;
				lk_ok_r <= 1'b0;
				miso_oe_o <= 1'b0;
			end else if (state_r != SM_IDLE && !sel_s2_r && sck_rise) begin
				sh_in_r <= sh_nxt;
				bit_cnt_r <= bit_cnt_r + 3'h1;
				case (state_r)
				SM_OPC: begin
					if (bit_cnt_r == 3'h7) begin
						opc_r <= sh_nxt;
						if (is_read_op(sh_nxt) || is_write_op(sh_nxt)) begin
							state_r <= SM_ADR;
						end else begin
							state_r <= SM_SKIP;
						end
						// (RQ22) write enable sets the latch
						if (sh_nxt == OP_WRITE_LATCH_SET_CMD && !write_busy_flag_o) begin
							write_enable_latch_o <= 1'b1;
						end
						if (sh_nxt == OP_WRDI && !write_busy_flag_o) begin
							write_enable_latch_o <= 1'b0;
						end
					end
				end
				SM_ADR: begin
					if (bit_cnt_r == 3'h7) begin
						adr_cnt_r <= 1'b1;
						adr_hi_r <= sh_nxt;
						if (adr_cnt_r) begin
							ofs_r <= ofs_nxt;
							if (is_read_op(opc_r)) begin
								if (write_busy_flag_o) begin
									// (RQ6) reads ignored during a write
									state_r <= SM_SKIP;
								end else begin
									state_r <= SM_RDAT;
									// (RQ8) region bit 1 selects lock status
									lock_rd_r <= region_nxt;
									// (RQ2) byte at the low offset bits
									out_sh_r <= region_nxt ? stat_byte : page_r[ofs_nxt];
								end
							end else begin
								state_r <= SM_WDAT;
								// (RQ24) locked page refuses writes
								wr_ok_r <= !region_nxt && write_enable_latch_o &&
									!write_busy_flag_o && !id_locked_o;
								// (RQ11) lock needs the latch set
								lk_ok_r <= region_nxt && write_enable_latch_o &&
									!write_busy_flag_o;
							end
						end
					end
				end
				SM_WDAT: begin
					if (bit_cnt_r == 3'h7) begin
						if (nbytes_r != 2'h3) begin
							nbytes_r <= nbytes_r + 2'h1;
						end
						// (RQ12) only data bit one matters
						lock_bit_r <= sh_nxt[`SEIDPL_LOCK_DATA_BIT];
						if (wr_ok_r && fifo_in_ready) begin
							push_r <= 1'b1;
							push_data_r <= {ofs_r, sh_nxt};
							ofs_r <= ofs_inc;
						end
					end
				end
				SM_RDAT: begin
					if (bit_cnt_r == 3'h7) begin
						if (lock_rd_r) begin
							// (RQ10) status byte repeats
							out_sh_r <= stat_byte;
						end else begin
							// (RQ3) next byte at incremented offset
							ofs_r <= ofs_inc;
							out_sh_r <= page_r[ofs_inc];
						end
					end
				end
				default: begin
				end
				endcase
			end else if (state_r == SM_RDAT && !sel_s2_r && sck_fall) begin
				miso_o <= out_sh_r[7];
				out_sh_r <= {out_sh_r[6:0], 1'b0};
				miso_oe_o <= 1'b1;
			end
		end
	end
endmodule

`default_nettype wire

/* File: seidpl_core_assertions.sv */
// Checker for the identification-page block
`timescale 1ns/1ps
`default_nettype none
`include "seidpl_map.vh"
module seidpl_core_assertions #(
	parameter WRITE_TIME_NS = `SEIDPL_WRITE_TIME_NS
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic sel_n_i,
	input wire logic sck_i,
	input wire logic mosi_i,
	input wire logic protect_level_hi_i,
	input wire logic protect_level_lo_i,
	input wire logic miso_o,
	input wire logic miso_oe_o,
	input wire logic write_enable_latch_o,
	input wire logic write_busy_flag_o,
	input wire logic id_locked_o
);
	localparam int CYC = WRITE_TIME_NS / `SEIDPL_CLK_PERIOD_NS;
	int busy_cnt_r;
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			busy_cnt_r <= 0;
		else
			busy_cnt_r <= write_busy_flag_o ? busy_cnt_r + 1 : 0;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	a_busy_length: assert property ($fell(write_busy_flag_o) |->
		busy_cnt_r inside {[CYC-1:CYC+1]}) else $error("busy length off");
	a_lock_sticky: assert property (id_locked_o |=> id_locked_o)
		else $error("lock flag dropped");
	a_lock_at_end: assert property ($rose(id_locked_o) |->
		$fell(write_busy_flag_o)) else $error("lock not at write end");
	a_busy_needs_latch: assert property ($rose(write_busy_flag_o) |->
		$past(write_enable_latch_o)) else $error("write without latch");
	a_latch_cleared: assert property ($rose(write_busy_flag_o) |->
		##[0:4] !write_enable_latch_o) else $error("latch kept after commit");
	a_latch_set_idle: assert property ($rose(write_enable_latch_o) |->
		!$past(write_busy_flag_o)) else $error("latch set while busy");
	a_oe_deselected: assert property (sel_n_i [*6] |-> !miso_oe_o)
		else $error("output on while deselected");
	a_oe_drop_cause: assert property ($fell(miso_oe_o) |->
		$past(sel_n_i, 2)) else $error("output dropped inside frame");
	a_reset_quiet: assert property ($fell(sys_rst_i) |->
		!(miso_oe_o | write_busy_flag_o | write_enable_latch_o | id_locked_o))
		else $error("outputs not cleared by reset");
	c_lock: cover property ($rose(id_locked_o));
	c_busy: cover property ($rose(write_busy_flag_o));
	c_read: cover property ($rose(miso_oe_o));
endmodule
bind seidpl_core seidpl_core_assertions #(.WRITE_TIME_NS(WRITE_TIME_NS)) i_chk (
	.clk_i(clk_i), .sys_rst_i(sys_rst_i), .sel_n_i(sel_n_i), .sck_i(sck_i),
	.mosi_i(mosi_i), .protect_level_hi_i(protect_level_hi_i),
	.protect_level_lo_i(protect_level_lo_i), .miso_o(miso_o), .miso_oe_o(miso_oe_o),
	.write_enable_latch_o(write_enable_latch_o), .write_busy_flag_o(write_busy_flag_o),
	.id_locked_o(id_locked_o));
`default_nettype wire

/* File: seidpl_spi_master.sv */
// SPI bus master model driving select, clock and data
`timescale 1ns/1ps
`default_nettype none
module seidpl_spi_master (
	input wire logic clk_i,
	output logic sel_n_o,
	output logic sck_o,
	output logic mosi_o,
	input wire logic miso_i,
	input wire logic miso_oe_i
);
	logic [7:0] rx [0:7];
	logic oe_seen;
	initial begin
		sel_n_o = 1'b1;
		sck_o = 1'b0;
		mosi_o = 1'b0;
		oe_seen = 1'b0;
	end
	always @(posedge miso_oe_i) oe_seen = 1'b1;
	// opcode, address, data bytes MSB first
	task automatic frame(input logic [7:0] op, input logic [15:0] adr,
		input int nbits, input logic [7:0] wb);
		logic [7:0] d;
		// Pins move just after a system clock edge, never on it
		@(posedge clk_i);
		#1 oe_seen = 1'b0;
		sel_n_o = 1'b0;
		#24;
		for (int i = 0; i < nbits; i++) begin
			d = wb + 8'((i - 24) / 8);
			mosi_o = i < 8 ? op[7-i] : i < 24 ? adr[23-i] : d[7-(i-24)%8];
			#24 sck_o = 1'b1;
			// A released data line reads back inverted
			if (i >= 24)
				rx[(i-24)/8][7-(i-24)%8] = miso_oe_i ? miso_i : ~miso_i;
			#24 sck_o = 1'b0;
		end
		// select rises before the next clock rise
		#24 sel_n_o = 1'b1;
		mosi_o = ~mosi_o;
		#48;
	endtask
endmodule
`default_nettype wire

/* File: spi_eeprom_id_page_lock_test.sv */
// Self-checking bench of the identification-page block
`timescale 1ns/1ps
`default_nettype none
`include "seidpl_map.vh"
module spi_eeprom_id_page_lock_test;
	logic clk_i = 0, sys_rst_i = 1, hi = 0, lo = 0;
	wire sel_n, sck, mosi, miso, oe, we_latch, busy, locked;
	int num_errors = 0, n_tests = 0;
	seidpl_core #(.WRITE_TIME_NS(1600)) i_seidpl_core (.clk_i(clk_i),
		.sys_rst_i(sys_rst_i), .sel_n_i(sel_n), .sck_i(sck), .mosi_i(mosi),
		.protect_level_hi_i(hi), .protect_level_lo_i(lo), .miso_o(miso),
		.miso_oe_o(oe), .write_enable_latch_o(we_latch), .write_busy_flag_o(busy),
		.id_locked_o(locked));
	seidpl_spi_master i_m (.clk_i(clk_i), .sel_n_o(sel_n), .sck_o(sck), .mosi_o(mosi),
		.miso_i(miso), .miso_oe_i(oe));
	initial begin
		forever #2 clk_i = ~clk_i;
	end
	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value at %0t: byte %h, want %h", $time, g, e);
		end
	endtask
	task automatic chk1(input logic g, input logic e);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value at %0t: flag %b, want %b", $time, g, e);
		end
	endtask
	task automatic wait_write();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 1000) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		chk1(busy, 1'b0);
	endtask
	task automatic write_latch_set_cmd();
		i_m.frame(`SEIDPL_OP_WRITE_LATCH_SET_CMD, 16'h0, 8, 8'h0);
	endtask
	task automatic end_of_test();
		$display("checks %0d, errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#200000;
		num_errors++;
		end_of_test();
	end
	initial begin
		repeat (12) @(posedge clk_i);
		#1 sys_rst_i = 0;
		repeat (4) @(posedge clk_i);
		#1 chk1(we_latch | busy | locked | oe, 1'b0);
		i_m.frame(`SEIDPL_OP_RD_ID, 16'h0003, 40, 8'h0);
		chk8(i_m.rx[1], `SEIDPL_ERASED_BYTE);
		i_m.frame(`SEIDPL_OP_RD_LOCK, 16'h0400, 32, 8'h0);
		chk8(i_m.rx[0], 8'h00);
		write_latch_set_cmd();
		chk1(we_latch, 1'b1);
		i_m.frame(`SEIDPL_OP_WR_ID, 16'hf805, 48, 8'ha0);
		chk1(busy, 1'b1);
		wait_write();
		i_m.frame(`SEIDPL_OP_RD_ID, 16'hfbe5, 56, 8'h0);
		for (int k = 0; k < 4; k++)
			chk8(i_m.rx[k], k < 3 ? 8'ha0 + 8'(k) : 8'hff);
		write_latch_set_cmd();
		i_m.frame(`SEIDPL_OP_WR_ID, 16'h0000, 32, 8'h55);
		i_m.frame(`SEIDPL_OP_RD_ID, 16'h0000, 32, 8'h0);
		chk1(i_m.oe_seen, 1'b0);
		wait_write();
		i_m.frame(`SEIDPL_OP_LOCK_ID, 16'h0400, 32, 8'h02);
		chk1(busy, 1'b0);
		write_latch_set_cmd();
		i_m.frame(`SEIDPL_OP_LOCK_ID, 16'h0400, 32, 8'hfd);
		chk1(busy, 1'b0);
		hi = 1;
		lo = 1;
		i_m.frame(`SEIDPL_OP_LOCK_ID, 16'h0400, 32, 8'h02);
		chk1(busy, 1'b0);
		hi = 0;
		i_m.frame(`SEIDPL_OP_LOCK_ID, 16'h0400, 33, 8'h02);
		chk1(busy, 1'b0);
		chk1(we_latch, 1'b1);
		i_m.frame(`SEIDPL_OP_LOCK_ID, 16'hffff, 32, 8'h02);
		chk1(busy, 1'b1);
		wait_write();
		chk1(locked, 1'b1);
		i_m.frame(`SEIDPL_OP_RD_LOCK, 16'h0400, 40, 8'h0);
		chk8(i_m.rx[1], 8'h01);
		write_latch_set_cmd();
		i_m.frame(`SEIDPL_OP_WR_ID, 16'h0005, 32, 8'h00);
		chk1(busy, 1'b0);
		i_m.frame(`SEIDPL_OP_RD_ID, 16'h0000, 72, 8'h0);
		chk8(i_m.rx[0], 8'h55);
		chk8(i_m.rx[5], 8'ha0);
		i_m.frame(`SEIDPL_OP_WRDI, 16'h0000, 8, 8'h0);
		chk1(we_latch, 1'b0);
		end_of_test();
	end
endmodule
`default_nettype wire
